// *** tqo_pkg.sv ***
// Contract
// RULE_01: Two-phase counting takes events from the aux input and aux output pin pair.
// RULE_02: Two-phase overflow or underflow reloads and continues unless free-run is set.
// RULE_03: Divide by FFFF minus n plus 1 counting up, n plus 1 counting down.
// RULE_04: Two-phase counter runs while start flag is one, halts when cleared.
// RULE_05: Two-phase overflow or underflow raises the channel interrupt request.
// RULE_06: Software sets both aux pins as inputs before two-phase counting.
// RULE_07: Two-phase count register read returns the live counter.
// RULE_08: Count write while stopped updates reload register and counter.
// RULE_09: Count write while counting updates reload only; counter takes it at reload.
// RULE_10: Normal processing: aux output high, input rise counts up, fall counts down.
// RULE_11: Multiply-by-4 counts all edges; input leading counts up, otherwise down. Code counts up when the output pin leads, down when the input pin leads.
// RULE_12: Channel 3 selects processing; channel 2 fixed normal, channel 4 fixed x4.
// RULE_13: One-shot counter decrements once per selected prescaled clock tick.
// RULE_14: One-shot reaching zero reloads the reload value and stops.
// RULE_15: One-shot trigger while running reloads and restarts counting.
// RULE_16: One-shot starts on external trigger, source overflow, or software start.
// RULE_17: One-shot stops after the zero reload or when start flag clears.
// RULE_18: One-shot raises the channel interrupt request when count reaches zero.
// RULE_19: One-shot aux input pin is port pin or external trigger input.
// RULE_20: One-shot aux output pin is port pin or pulse output.
// RULE_21: One-shot count register read value is undefined.
// RULE_22: Free-run mode wraps on overflow or underflow without reloading.
// RULE_23: Counter, reload register and count register are sixteen bits.
// RULE_24: One-shot run length equals the set value in clock ticks.
package tqo_pkg;

  // ==========================================================
  // Widths
  localparam int CNT_W  = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_COUNT   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ONESHOT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PORTDIR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PORTDAT = 8'h14;

  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_W          = 10;
  localparam int ONESHOT_GO_BIT  = 0;
  localparam logic [CNT_W-1:0]  CNT_MAX      = 16'hFFFF;
  localparam logic [CNT_W-1:0]  CNT_ZERO     = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE      = 16'h0001;
  localparam logic [CNT_W-1:0]  COUNT_RST    = 16'h0000;
  localparam logic [1:0]        PORT_RST     = 2'h0;

  // ==========================================================
  // Prescaler counts
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] DIV8_LAST  = 5'h07;
  localparam logic [DIV_W-1:0] DIV32_LAST = 5'h1F;
  localparam logic [2:0]       DIV8_MASK  = 3'h7;

  // ==========================================================
  // Clock source select
  typedef enum logic [1:0] {
    CLK_MAIN_DIV1  = 2'h0,
    CLK_MAIN_DIV8  = 2'h1,
    CLK_MAIN_DIV32 = 2'h2,
    CLK_SUB_DIV32  = 2'h3
  } tqo_clksel_e;

  // ==========================================================
  // One-shot state
  typedef enum logic [1:0] {
    OS_IDLE = 2'b00,
    OS_RUN  = 2'b01
  } tqo_state_e;

  // ==========================================================
  // Control register layout, bit 0 is start
  typedef struct packed {
    logic        pulse_en;
    logic        trig_ovf;
    logic        trig_rise;
    logic        trig_ext;
    tqo_clksel_e clksel;
    logic        mul4;
    logic        free_run;
    logic        oneshot;
    logic        start;
  } tqo_ctrl_s;

  localparam tqo_ctrl_s CTRL_RST = 10'h000;

endpackage

// *** tqo_timer.sv ***
// Chosen here: the register offsets and register access over APB.
module tqo_timer
  import tqo_pkg::*;
#(
  parameter int CHANNEL_ID = 3
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              aux_input_pin_i,
  output logic                   aux_input_pin_o,
  output logic                   aux_input_pin_oe,
  input  wire logic              aux_output_pin_i,
  output logic                   aux_output_pin_o,
  output logic                   aux_output_pin_oe,
  input  wire logic              subclock_tick,
  input  wire logic              src_overflow,
  output logic                   irq_pulse
);

  // ==========================================================
  // Registers
  tqo_ctrl_s               ctrl_reg;
  tqo_ctrl_s               ctrl_next;
  logic [CNT_W-1:0]        cnt_reg;
  logic [CNT_W-1:0]        cnt_next;
  logic [CNT_W-1:0]        reload_reg;
  logic [CNT_W-1:0]        reload_next;
  tqo_state_e              state_reg;
  tqo_state_e              state_next;
  logic [1:0]              dir_reg;
  logic [1:0]              dat_reg;
  logic                    in_prev_reg;
  logic                    out_prev_reg;
  logic                    prev_ok_reg;
  logic [DIV_W-1:0]        main_div_reg;
  logic [DIV_W-1:0]        sub_div_reg;
  logic                    irq_reg;
  logic                    irq_next;
  logic [DATA_W-1:0]       rdata_reg;
  logic                    err_reg;

  // ==========================================================
  // Bus decode
  wire                     setup_ph   = psel & ~penable;
  wire                     access_ph  = psel & penable;
  wire                     wr_en      = access_ph & pwrite;
  wire                     hit_count  = (paddr == OFS_COUNT);
  wire                     hit_ctrl   = (paddr == OFS_CTRL);
  wire                     hit_os     = (paddr == OFS_ONESHOT);
  wire                     hit_status = (paddr == OFS_STATUS);
  wire                     hit_dir    = (paddr == OFS_PORTDIR);
  wire                     hit_dat    = (paddr == OFS_PORTDAT);
  wire                     hit_any    = hit_count | hit_ctrl | hit_os | hit_status |
                                        hit_dir | hit_dat;
  wire                     wr_count   = wr_en & hit_count;
  wire                     wr_ctrl    = wr_en & hit_ctrl;
  wire                     wr_os      = wr_en & hit_os;
  wire                     wr_dir     = wr_en & hit_dir;
  wire                     wr_dat     = wr_en & hit_dat;
  wire [CNT_W-1:0]         wr_val     = pwdata[CNT_W-1:0];

  // ==========================================================
  // Mode qualifiers
  wire                     mul4_sel   = (CHANNEL_ID == 3) ? ctrl_reg.mul4 :
                                        (CHANNEL_ID == 4);  // RULE_12
  wire                     tp_active  = ~ctrl_reg.oneshot & ctrl_reg.start;  // RULE_04
  wire                     os_enable  = ctrl_reg.oneshot & ctrl_reg.start;
  wire                     os_running = (state_reg == OS_RUN);
  wire                     busy       = tp_active | os_running;
  wire [CNT_W-1:0]         load_val   = wr_count ? wr_val : reload_reg;  // RULE_09

  // ==========================================================
  // Pin edge detection
  wire                     in_rise    = prev_ok_reg & aux_input_pin_i & ~in_prev_reg;
  wire                     in_fall    = prev_ok_reg & ~aux_input_pin_i & in_prev_reg;
  wire                     in_chg     = prev_ok_reg & (aux_input_pin_i ^ in_prev_reg);
  wire                     out_chg    = prev_ok_reg & (aux_output_pin_i ^ out_prev_reg);

  // ==========================================================
  // Two-phase step decode
  wire                     n_up       = aux_output_pin_i & in_rise;  // RULE_10
  wire                     n_dn       = aux_output_pin_i & in_fall;  // RULE_10
  wire                     m4_step    = in_chg ^ out_chg;  // RULE_11
  wire                     m4_dir_up  = in_prev_reg ^ aux_output_pin_i;  // RULE_11
  wire                     m4_up      = m4_step & m4_dir_up;
  wire                     m4_dn      = m4_step & ~m4_dir_up;
  wire                     tp_up      = tp_active & (mul4_sel ? m4_up : n_up);  // RULE_01
  wire                     tp_dn      = tp_active & (mul4_sel ? m4_dn : n_dn);  // RULE_01
  wire                     tp_ovf     = tp_up & (cnt_reg == CNT_MAX);
  wire                     tp_unf     = tp_dn & (cnt_reg == CNT_ZERO);
  wire                     tp_wrap    = tp_ovf | tp_unf;

  // ==========================================================
  // Prescaled ticks
  wire                     tick_div8  = (main_div_reg[2:0] == DIV8_MASK);
  wire                     tick_div32 = (main_div_reg == DIV32_LAST);
  wire                     tick_sub   = subclock_tick & (sub_div_reg == DIV32_LAST);
  logic                    os_tick;

  always_comb begin
    case (ctrl_reg.clksel)
      CLK_MAIN_DIV1:  os_tick = 1'b1;
      CLK_MAIN_DIV8:  os_tick = tick_div8;
      CLK_MAIN_DIV32: os_tick = tick_div32;
      CLK_SUB_DIV32:  os_tick = tick_sub;
      default:        os_tick = 1'b0;
    endcase
  end

  // ==========================================================
  // One-shot triggers
  wire                     ext_edge   = ctrl_reg.trig_rise ? in_rise : in_fall;
  wire                     trig_ext   = ctrl_reg.trig_ext & ext_edge;  // RULE_19
  wire                     trig_ovf   = ctrl_reg.trig_ovf & src_overflow;
  wire                     trig_sw    = wr_os & pwdata[ONESHOT_GO_BIT];
  wire                     os_trigger = os_enable & (trig_ext | trig_ovf | trig_sw);  // RULE_16
  wire                     os_last    = (cnt_reg <= CNT_ONE);

  // ==========================================================
  // Counter, reload and state next values
  always_comb begin
    cnt_next    = cnt_reg;
    reload_next = reload_reg;
    state_next  = state_reg;
    irq_next    = 1'b0;
    if (wr_count) begin
      reload_next = wr_val;  // RULE_09
      if (!busy) begin
        cnt_next = wr_val;  // RULE_08
      end
    end
    if (tp_wrap) begin
      irq_next = 1'b1;  // RULE_05
      if (ctrl_reg.free_run) begin
        cnt_next = tp_ovf ? CNT_ZERO : CNT_MAX;  // RULE_22
      end else begin
        cnt_next = load_val;  // RULE_02 RULE_03
      end
    end else if (tp_up) begin
      cnt_next = cnt_reg + CNT_ONE;
    end else if (tp_dn) begin
      cnt_next = cnt_reg - CNT_ONE;
    end
    case (state_reg)
      OS_IDLE: begin
        if (os_trigger) begin
          cnt_next   = load_val;
          state_next = OS_RUN;
        end
      end
      OS_RUN: begin
        if (!os_enable) begin
          state_next = OS_IDLE;  // RULE_17
        end else if (os_trigger) begin
          cnt_next = load_val;  // RULE_15
        end else if (os_tick) begin
          if (os_last) begin
            cnt_next   = load_val;  // RULE_14
            state_next = OS_IDLE;  // RULE_17
            irq_next   = 1'b1;  // RULE_18
          end else begin
            cnt_next = cnt_reg - CNT_ONE;  // RULE_13 RULE_24
          end
        end
      end
      default: begin
        state_next = OS_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Control next value
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = tqo_ctrl_s'(pwdata[CTRL_W-1:0]);
    end
  end

  // ==========================================================
  // Read mux
  wire [DATA_W-1:0]        rd_count   = {{(DATA_W-CNT_W){1'b0}}, cnt_reg};  // RULE_07 RULE_21
  wire [DATA_W-1:0]        rd_ctrl    = {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
  wire [DATA_W-1:0]        rd_status  = {28'h000_0000, aux_output_pin_i, aux_input_pin_i,
                                         aux_output_pin_o, os_running};
  wire [DATA_W-1:0]        rd_dir     = {{(DATA_W-2){1'b0}}, dir_reg};
  wire [DATA_W-1:0]        rd_dat     = {28'h000_0000, aux_output_pin_i, aux_input_pin_i,
                                         dat_reg};
  wire [DATA_W-1:0]        rd_mux     = hit_count  ? rd_count  :
                                        hit_ctrl   ? rd_ctrl   :
                                        hit_status ? rd_status :
                                        hit_dir    ? rd_dir    :
                                        hit_dat    ? rd_dat    : 32'h0000_0000;

  // ==========================================================
  // Bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else if (setup_ph) begin
      rdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      err_reg   <= ~hit_any;
    end
  end

  assign prdata  = rdata_reg;
  assign pready  = 1'b1;
  assign pslverr = err_reg & access_ph;

  // ==========================================================
  // Core registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= CTRL_RST;
      cnt_reg    <= COUNT_RST;
      reload_reg <= COUNT_RST;
      state_reg  <= OS_IDLE;
      irq_reg    <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      cnt_reg    <= cnt_next;  // RULE_23
      reload_reg <= reload_next;  // RULE_23
      state_reg  <= state_next;
      irq_reg    <= irq_next;
    end
  end

  // ==========================================================
  // Port registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg <= PORT_RST;
      dat_reg <= PORT_RST;
    end else begin
      if (wr_dir) begin
        dir_reg <= pwdata[1:0];  // RULE_06
      end
      if (wr_dat) begin
        dat_reg <= pwdata[1:0];
      end
    end
  end

  // ==========================================================
  // Pin history and prescalers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_prev_reg  <= 1'b0;
      out_prev_reg <= 1'b0;
      prev_ok_reg  <= 1'b0;
      main_div_reg <= 5'h00;
      sub_div_reg  <= 5'h00;
    end else begin
      in_prev_reg  <= aux_input_pin_i;
      out_prev_reg <= aux_output_pin_i;
      prev_ok_reg  <= 1'b1;
      main_div_reg <= main_div_reg + 5'h01;
      if (subclock_tick) begin
        sub_div_reg <= sub_div_reg + 5'h01;
      end
    end
  end

  // ==========================================================
  // Pin drive
  wire                     pulse_mode = ctrl_reg.oneshot & ctrl_reg.pulse_en;
  wire                     trig_mode  = ctrl_reg.oneshot & ctrl_reg.trig_ext;

  assign aux_input_pin_o   = dat_reg[0];
  assign aux_input_pin_oe  = dir_reg[0] & ~trig_mode;  // RULE_19
  assign aux_output_pin_o  = pulse_mode ? os_running : dat_reg[1];  // RULE_20
  assign aux_output_pin_oe = pulse_mode | dir_reg[1];  // RULE_20
  assign irq_pulse         = irq_reg;

endmodule

// *** tqo_timer_props.sv ***
module tqo_timer_props
  import tqo_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic              pready,
  input wire logic              aux_input_pin_oe,
  input wire logic              aux_output_pin_o,
  input wire logic              aux_output_pin_oe,
  input wire logic              src_overflow,
  input wire logic              irq_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================
  // Shadow of control and direction
  tqo_ctrl_s  ctl_reg;
  logic [1:0] dir_reg;
  logic       wr_en;
  logic       trg;
  logic       pls;
  assign wr_en = psel && penable && pwrite && pready;
  assign trg   = ctl_reg.oneshot && ctl_reg.trig_ext;
  assign pls   = ctl_reg.oneshot && ctl_reg.pulse_en;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= CTRL_RST;
      dir_reg <= PORT_RST;
    end else if (wr_en && paddr == OFS_CTRL) begin
      ctl_reg <= tqo_ctrl_s'(pwdata[CTRL_W-1:0]);
    end else if (wr_en && paddr == OFS_PORTDIR) begin
      dir_reg <= pwdata[1:0];
    end
  end
  // ==========================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_trig_pin_input: assert property (trg |-> !aux_input_pin_oe)
    else $error("trigger pin driven");
  a_port_in_dir: assert property (!trg |-> aux_input_pin_oe == dir_reg[0])
    else $error("aux input enable wrong");
  a_pulse_pin_drive: assert property (pls |-> aux_output_pin_oe)
    else $error("pulse pin not driven");
  a_port_out_dir: assert property (!pls |-> aux_output_pin_oe == dir_reg[1])
    else $error("aux output enable wrong");
  a_stop_no_irq: assert property (!ctl_reg.start && !$past(ctl_reg.start) |-> !irq_pulse)
    else $error("irq while stopped");
  a_done_irq: assert property (pls && $past(pls) && ctl_reg.start && $fell(aux_output_pin_o)
    |-> ##[0:1] irq_pulse)
    else $error("no irq at end of run");
  a_ovf_starts: assert property (pls && ctl_reg.start && ctl_reg.trig_ovf && src_overflow
    |-> ##[1:2] aux_output_pin_o)
    else $error("overflow did not start");
  a_stopped_quiet: assert property (pls && !ctl_reg.start && !$past(ctl_reg.start)
    |-> !aux_output_pin_o)
    else $error("pulse while stopped");
endmodule

bind tqo_timer tqo_timer_props tqo_timer_props_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .aux_input_pin_oe, .aux_output_pin_o, .aux_output_pin_oe,
  .src_overflow, .irq_pulse);

// *** tqo_quad_src.sv ***
module tqo_quad_src (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic step,
  input  wire logic up,
  input  wire logic trig,
  output logic      aux_in,
  output logic      aux_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================
  // Gray phase walk, one pin per step
  logic [1:0] ph_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_reg <= 2'h0;
    end else if (step) begin
      ph_reg <= up ? ph_reg + 2'h1 : ph_reg - 2'h1;
    end
  end
  // Up order: output pin rises before input pin
  assign aux_in  = ph_reg[1] | trig;
  assign aux_out = ph_reg[1] ^ ph_reg[0];
endmodule

// *** tb_timer_quadrature_oneshot.sv ***
module tb_timer_quadrature_oneshot
  import tqo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("mismatch at %0t: got %0h exp %0h", $time, (a), (b)); end end
  logic              pclk, presetn, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic              pready, pslverr, in_o, in_oe, out_o, out_oe, sub_tick, src_ovf, irq;
  logic              step, up, trig, src_a, src_b, in_w, out_w;
  int                error_cnt, checks, irq_n;
  assign in_w  = in_oe ? in_o : src_a;
  assign out_w = out_oe ? out_o : src_b;
  tqo_timer #(.CHANNEL_ID(3)) tqo_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .aux_input_pin_i(in_w), .aux_input_pin_o(in_o),
    .aux_input_pin_oe(in_oe), .aux_output_pin_i(out_w), .aux_output_pin_o(out_o),
    .aux_output_pin_oe(out_oe), .subclock_tick(sub_tick), .src_overflow(src_ovf),
    .irq_pulse(irq));
  tqo_quad_src tqo_quad_src_i (.pclk(pclk), .presetn(presetn), .step(step), .up(up),
    .trig(trig), .aux_in(src_a), .aux_out(src_b));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) if (irq === 1'b1) irq_n++;
  // ==========================
  // Bus and stimulus tasks
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] q, output logic e);
    if (psel === 1'b1) @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    logic              e;
    apb(a, 1'b1, d, q, e);
  endtask
  task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
    logic [DATA_W-1:0] q;
    logic              e;
    apb(a, 1'b0, 32'h0000_0000, q, e);
    `CHK(q, x)
  endtask
  task automatic stp(input logic u, input int n);
    repeat (n) begin
      step <= 1'b1;
      up   <= u;
      @(posedge pclk);
      step <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
  task automatic os_run(input int src, input int rt, input int exp_n);
    int n, i0;
    n  = 0;
    i0 = irq_n;
    if (src == 0) wr(OFS_ONESHOT, 32'h0000_0001);
    else begin
      src_ovf <= (src == 1);
      trig    <= (src == 2);
      @(posedge pclk);
      src_ovf <= 1'b0;
      trig    <= 1'b0;
    end
    for (int i = 0; i < 24; i++) begin
      #1 if (out_o === 1'b1) n++;
      @(posedge pclk);
      if (i + 1 == rt) src_ovf <= 1'b1;
      else if (src_ovf === 1'b1) src_ovf <= 1'b0;
    end
    `CHK(n, exp_n)
    `CHK(irq_n - i0, int'(exp_n != 0))
  endtask
  // ==========================
  // Scenarios
  task automatic test_regs();
    logic [DATA_W-1:0] q;
    logic              e;
    wr(OFS_PORTDIR, 32'h0000_0000);
    wr(OFS_PORTDAT, 32'h0000_0001);
    #1 `CHK(in_o, 1'b1)
    @(posedge pclk);
    wr(OFS_COUNT, 32'hABCD_1234);
    chk_rd(OFS_COUNT, 32'h0000_1234);
    apb(8'h40, 1'b0, 32'h0000_0000, q, e);
    `CHK(e, 1'b1)
    $display("test_regs done");
  endtask
  task automatic test_quad();
    int n0;
    wr(OFS_COUNT, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0009);
    wr(OFS_COUNT, 32'h0000_0003);
    chk_rd(OFS_COUNT, 32'h0000_0001);
    n0 = irq_n;
    stp(1'b0, 2);
    chk_rd(OFS_COUNT, 32'h0000_0003);
    `CHK(irq_n - n0, 1)
    stp(1'b1, 4);
    chk_rd(OFS_COUNT, 32'h0000_0007);
    $display("test_quad done");
  endtask
  task automatic test_normal();
    int n0;
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_COUNT, 32'h0000_FFFE);
    wr(OFS_CTRL, 32'h0000_0001);
    n0 = irq_n;
    stp(1'b1, 8);
    chk_rd(OFS_COUNT, 32'h0000_FFFE);
    `CHK(irq_n - n0, 1)
    stp(1'b0, 4);
    chk_rd(OFS_COUNT, 32'h0000_FFFD);
    wr(OFS_CTRL, 32'h0000_0005);
    stp(1'b1, 12);
    chk_rd(OFS_COUNT, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0004);
    stp(1'b1, 4);
    chk_rd(OFS_COUNT, 32'h0000_0000);
    $display("test_normal done");
  endtask
  task automatic test_oneshot();
    wr(OFS_CTRL, 32'h0000_0000);
    stp(1'b1, 2);
    wr(OFS_COUNT, 32'h0000_0005);
    wr(OFS_CTRL, 32'h0000_0303);
    os_run(0, 0, 5);
    os_run(1, 2, 8);
    wr(OFS_CTRL, 32'h0000_02C3);
    os_run(2, 0, 5);
    wr(OFS_CTRL, 32'h0000_0302);
    os_run(0, 0, 0);
    wr(OFS_COUNT, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0313);
    wr(OFS_ONESHOT, 32'h0000_0001);
    repeat (8) @(posedge pclk);
    #1 `CHK(out_o, 1'b1)
    repeat (8) @(posedge pclk);
    #1 `CHK(out_o, 1'b0)
    $display("test_oneshot done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, sub_tick, src_ovf, step, up, trig} = '0;
    paddr  = '0;
    pwdata = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_regs();
    test_quad();
    test_normal();
    test_oneshot();
    report_and_stop();
  end
  initial begin
    #100us;
    error_cnt++;
    report_and_stop();
  end
endmodule
